// ---- rtl/rcsc_pkg.sv ----
// Purpose: shared constants, types and helpers for the reset and clock-source control block
// Assumes: one clock aclk at 200 MHz, AXI4-Lite register access with 32-bit data
// Notes: offsets are byte addresses of aligned 32-bit words
`default_nettype none

package rcsc_pkg;

  localparam int AXI_AW = 8;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } rcsc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcsc_axi_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register map
  localparam logic [AXI_AW-1:0] OFS_PBOR_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_RESET_CAUSE = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_SOFT_RESET0 = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_CLK_GATE0 = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_RUN_CLK_CFG = 8'h20;
  localparam logic [AXI_AW-1:0] OFS_RUN_CLK_CFG_EXT = 8'h24;
  localparam logic [AXI_AW-1:0] OFS_WDOG_LOAD = 8'h28;
  localparam logic [AXI_AW-1:0] OFS_WDOG_VALUE = 8'h2c;
  localparam logic [AXI_AW-1:0] OFS_WDOG_CTRL = 8'h30;
  localparam logic [AXI_AW-1:0] OFS_WDOG_INT_CLEAR = 8'h34;
  localparam logic [AXI_AW-1:0] OFS_WDOG_STATUS = 8'h38;
  localparam logic [AXI_AW-1:0] OFS_SYS_RESET_CTRL = 8'h3c;
  localparam logic [AXI_AW-1:0] OFS_BOR_STATUS = 8'h40;

  // por_bor_control_register
  localparam int PBOR_RST_EN_BIT = 1;
  localparam logic [31:0] PBOR_WMASK = 32'h0000_0002;
  localparam logic [31:0] PBOR_RESET = 32'h0000_0000;

  // reset_cause_register
  localparam int CAUSE_W = 5;
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_WDOG = 3;
  localparam int CAUSE_SW = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h02;

  localparam int SYS_REQ_BIT = 0;

  // run_clock_config
  localparam int RCC_OSCSRC_LSB = 4;
  localparam int RCC_BYPASS_BIT = 11;
  localparam int RCC_PWRDN_BIT = 13;
  localparam int RCC_PWMDIV_LSB = 17;
  localparam int RCC_USEPWMDIV_BIT = 20;
  localparam int RCC_USESYSDIV_BIT = 22;
  localparam int RCC_SYSDIV_LSB = 23;
  localparam logic [31:0] RCC_RESET = 32'h078e_2810;

  // run_clock_config_ext
  localparam int EXT_OSCSRC_LSB = 4;
  localparam int EXT_BYPASS_BIT = 11;
  localparam int EXT_PWRDN_BIT = 13;
  localparam int EXT_SYSDIV_LSB = 23;
  localparam int EXT_USE_BIT = 31;
  localparam logic [31:0] EXT_RESET = 32'h0780_2810;

  typedef enum logic [2:0] {
    SRC_MAIN = 3'h0,
    SRC_IFAST = 3'h1,
    SRC_IFAST_DIV4 = 3'h2,
    SRC_LOW_30K = 3'h3,
    SRC_PLL = 3'h4,
    SRC_RTC = 3'h7
  } rcsc_clk_src_t;

  typedef enum logic [4:0] {
    BOOT_HOLD = 5'h01,
    BOOT_FETCH_SP = 5'h02,
    BOOT_FETCH_PC = 5'h04,
    BOOT_FETCH_INSN = 5'h08,
    BOOT_RUN = 5'h10
  } rcsc_boot_t;

  // watchdog
  localparam int WDOG_INTEN_BIT = 0;
  localparam int WDOG_RESEN_BIT = 1;
  localparam logic [31:0] WDOG_LOAD_RESET = 32'hffff_ffff;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;
  localparam int CLK_HZ = 200_000_000;
  localparam int CONV_CLK_HZ = 16_000_000;
  localparam int CONV_DIV = (CLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
  localparam int CONV_CNT_W = 4;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  function automatic logic [AXI_AW-1:0] reg_ofs(input logic [AXI_AW-1:0] base, input int idx);
    return base + AXI_AW'(idx << 2);
  endfunction : reg_ofs

endpackage : rcsc_pkg

`default_nettype wire

// ---- rtl/rcsc_wdog.sv ----
// Purpose: two-stage watchdog, interrupt on first time-out and reset request on second
// Assumes: synchronous active-low reset, counter enabled by int_en
// Notes: a time-out in the cycle of an interrupt clear keeps the flag set
`default_nettype none

module rcsc_wdog (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sys_reset,
  input wire logic [31:0] load_value,
  input wire logic load_wr,
  input wire logic int_en,
  input wire logic reset_en,
  input wire logic int_clear,
  output logic [31:0] count_q,
  output logic int_flag_q,
  output logic reset_req_q
);
  import rcsc_pkg::*;

  logic zero_evt;
  assign zero_evt = int_en && !load_wr && !sys_reset && (count_q == 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= WDOG_LOAD_RESET;
    end else if (sys_reset || load_wr || zero_evt) begin
      count_q <= load_value; // R12
    end else if (int_en) begin
      count_q <= count_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset) begin
      int_flag_q <= 1'b0;
    end else if (zero_evt) begin
      int_flag_q <= 1'b1; // R11
    end else if (int_clear) begin
      int_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= zero_evt && int_flag_q && reset_en; // R13
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_wdog_first_reload: assert property ( // R12
    (zero_evt && !int_flag_q) |=> (int_flag_q && count_q == $past(load_value)))
    else $error("first time-out did not reload and flag");
  a_wdog_second_reset: assert property ( // R13
    (zero_evt && int_flag_q && reset_en) |=> reset_req_q)
    else $error("second time-out did not request reset");
  a_wdog_reset_cause: assert property ( // R11
    reset_req_q |-> ($past(int_flag_q) && $past(reset_en)))
    else $error("reset request without pending first time-out");

endmodule : rcsc_wdog

`default_nettype wire

// ---- rtl/rcsc_top.sv ----
// Purpose: reset and clock-source control with AXI4-Lite registers
// Assumes: all inputs synchronous to aclk; aresetn is the power-up reset of this block
// Notes: system reset output holds a minimum width after its last source goes away
//
// Operation
// (R1) brown-out reset stays disabled after power-up until software enables it
// (R2) brown-out raises an interrupt or a system reset, by configuration
// (R3) brown-out resets only while brownout_reset_enable is set
// (R4) brown-out reset acts like external reset and holds while supply is low
// (R5) reset cause register records a brown-out cause
// (R6) setting then clearing a soft reset bit resets that peripheral only
// (R7) soft reset bit positions match clock gating bit positions
// (R8) a peripheral soft reset asserts every reset of that unit
// (R9) system reset request bit resets the whole system including the core
// (R10) after reset the core fetches stack pointer, program counter, first instruction
// (R11) watchdog interrupts on first time-out and may reset on the second
// (R12) first time-out reloads the 32-bit counter from the reload value
// (R13) watchdog resets only on second zero with flag pending and reset enabled
// (R14) run from the internal fast oscillator during and after power-on reset; por_active leaves rcc_q as programmed, so that source returns after it
// (R15) software enables and settles the main oscillator before switching to it
// (R16) system clock chosen from six sources including internal fast divided by four
// (R17) software keeps the PLL reference between 3.579545 and 8.192 MHz
// (R18) extended clock config fields take precedence when in use
// (R19) extended fields used only when use_extended_clock_config is set
// (R20) converter clock divided to 16 MHz without software
// (R21) PWM clock is a synchronous division of the system clock
// (R22) each peripheral clock individually enabled by software
// (R23) cause bits sticky across resets; power-on clears all but the power-on bit
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`default_nettype none

module rcsc_top #(
  parameter int NUM_UNIT_REGS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rcsc_pkg::rcsc_axi_req_t axi_req,
  output rcsc_pkg::rcsc_axi_rsp_t axi_rsp_q,
  input wire logic ext_reset_n,
  input wire logic por_active,
  input wire logic brownout_detect,
  input wire logic pll_locked,
  output logic sys_reset_q,
  output rcsc_pkg::rcsc_boot_t boot_step_q,
  output logic bor_irq_q,
  output logic wdog_irq_q,
  output logic [NUM_UNIT_REGS*32-1:0] periph_reset_q,
  output logic [NUM_UNIT_REGS*32-1:0] periph_clk_en_q,
  output rcsc_pkg::rcsc_clk_src_t clk_src_q,
  output logic [5:0] sysdiv_q,
  output logic use_sysdiv_q,
  output logic pll_power_down_q,
  output logic conv_clk_tick_q,
  output logic pwm_clk_tick_q
);
  import rcsc_pkg::*;

  logic [31:0] pbor_q;
  logic [31:0] rcc_q;
  logic [31:0] rcc_ext_q;
  logic [31:0] wdog_load_q;
  logic [1:0] wdog_ctrl_q;
  logic [CAUSE_W-1:0] cause_q;
  logic bor_prev_q;
  logic sw_req_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [7:0] pwm_cnt_q;
  logic [31:0] wdog_count;
  logic wdog_rst;
  logic wdog_load_wr_q;

  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;

  function automatic logic addr_known(input logic [AXI_AW-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      OFS_PBOR_CTRL, OFS_RESET_CAUSE, OFS_RUN_CLK_CFG, OFS_RUN_CLK_CFG_EXT, OFS_WDOG_LOAD,
      OFS_WDOG_VALUE, OFS_WDOG_CTRL, OFS_WDOG_INT_CLEAR, OFS_WDOG_STATUS, OFS_SYS_RESET_CTRL,
      OFS_BOR_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_UNIT_REGS; i++) begin
      if (a == reg_ofs(OFS_SOFT_RESET0, i) || a == reg_ofs(OFS_CLK_GATE0, i)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : addr_known

  function automatic rcsc_clk_src_t osc_decode(input logic [2:0] code);
    rcsc_clk_src_t s;
    case (code)
      3'h0: s = SRC_MAIN;
      3'h1: s = SRC_IFAST;
      3'h2: s = SRC_IFAST_DIV4;
      3'h3: s = SRC_LOW_30K;
      3'h7: s = SRC_RTC;
      default: s = SRC_IFAST;
    endcase
    return s;
  endfunction : osc_decode

  // register bus
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_en;
  logic [31:0] wr_merged;
  logic [31:0] rd_data;

  assign aw_fire = axi_req.awvalid && axi_rsp_q.awready;
  assign w_fire = axi_req.wvalid && axi_rsp_q.wready;
  assign ar_fire = axi_req.arvalid && axi_rsp_q.arready;
  assign wr_en = aw_have_q && w_have_q && !axi_rsp_q.bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp_q <= '0;
      axi_rsp_q.awready <= 1'b1;
      axi_rsp_q.wready <= 1'b1;
      axi_rsp_q.arready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        wr_addr_q <= axi_req.awaddr;
        axi_rsp_q.awready <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wr_data_q <= axi_req.wdata;
        wr_strb_q <= axi_req.wstrb;
        axi_rsp_q.wready <= 1'b0;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        axi_rsp_q.bvalid <= 1'b1;
        axi_rsp_q.bresp <= addr_known(wr_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_rsp_q.bvalid && axi_req.bready) begin
        axi_rsp_q.bvalid <= 1'b0;
        axi_rsp_q.awready <= 1'b1;
        axi_rsp_q.wready <= 1'b1;
      end
      if (ar_fire) begin
        axi_rsp_q.arready <= 1'b0;
        axi_rsp_q.rvalid <= 1'b1;
        axi_rsp_q.rdata <= rd_data;
        axi_rsp_q.rresp <= addr_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_rsp_q.rvalid && axi_req.rready) begin
        axi_rsp_q.rvalid <= 1'b0;
        axi_rsp_q.arready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (axi_req.araddr)
      OFS_PBOR_CTRL: rd_data = pbor_q;
      OFS_RESET_CAUSE: rd_data = {27'h0, cause_q};
      OFS_RUN_CLK_CFG: rd_data = rcc_q;
      OFS_RUN_CLK_CFG_EXT: rd_data = rcc_ext_q;
      OFS_WDOG_LOAD: rd_data = wdog_load_q;
      OFS_WDOG_VALUE: rd_data = wdog_count;
      OFS_WDOG_CTRL: rd_data = {30'h0, wdog_ctrl_q};
      OFS_WDOG_STATUS: rd_data = {31'h0, wdog_irq_q};
      OFS_BOR_STATUS: rd_data = {31'h0, bor_irq_q};
      default: rd_data = 32'h0000_0000;
    endcase
    for (int i = 0; i < NUM_UNIT_REGS; i++) begin
      if (axi_req.araddr == reg_ofs(OFS_SOFT_RESET0, i)) begin
        rd_data = periph_reset_q[i*32 +: 32];
      end
      if (axi_req.araddr == reg_ofs(OFS_CLK_GATE0, i)) begin
        rd_data = periph_clk_en_q[i*32 +: 32];
      end
    end
  end

  assign wr_merged = merge_strb(32'h0000_0000, wr_data_q, wr_strb_q);

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pbor_q <= PBOR_RESET; // R1
    end else if (wr_en && wr_addr_q == OFS_PBOR_CTRL) begin
      pbor_q <= merge_strb(pbor_q, wr_data_q, wr_strb_q) & PBOR_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcc_q <= RCC_RESET; // R14
      rcc_ext_q <= EXT_RESET;
    end else if (wr_en && wr_addr_q == OFS_RUN_CLK_CFG) begin
      rcc_q <= merge_strb(rcc_q, wr_data_q, wr_strb_q);
    end else if (wr_en && wr_addr_q == OFS_RUN_CLK_CFG_EXT) begin
      rcc_ext_q <= merge_strb(rcc_ext_q, wr_data_q, wr_strb_q);
    end
  end

  // soft reset and clock gate share one bit layout per unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_reset_q <= '0;
      periph_clk_en_q <= '0;
    end else begin
      for (int i = 0; i < NUM_UNIT_REGS; i++) begin
        if (wr_en && wr_addr_q == reg_ofs(OFS_SOFT_RESET0, i)) begin
          periph_reset_q[i*32 +: 32] <= merge_strb(periph_reset_q[i*32 +: 32], wr_data_q, wr_strb_q); // R6 R7 R8
        end
        if (wr_en && wr_addr_q == reg_ofs(OFS_CLK_GATE0, i)) begin
          periph_clk_en_q[i*32 +: 32] <= merge_strb(periph_clk_en_q[i*32 +: 32], wr_data_q, wr_strb_q); // R22
        end
      end
    end
  end

  // counter reloads one cycle after the write, from the new value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_load_q <= WDOG_LOAD_RESET;
      wdog_load_wr_q <= 1'b0;
    end else begin
      wdog_load_wr_q <= wr_en && wr_addr_q == OFS_WDOG_LOAD;
      if (wr_en && wr_addr_q == OFS_WDOG_LOAD) begin
        wdog_load_q <= merge_strb(wdog_load_q, wr_data_q, wr_strb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset_q) begin
      wdog_ctrl_q <= 2'h0;
    end else if (wr_en && wr_addr_q == OFS_WDOG_CTRL && wr_strb_q[0]) begin
      wdog_ctrl_q <= wr_data_q[1:0];
    end
  end

  rcsc_wdog u_wdog (
    .aclk(aclk),
    .aresetn(aresetn),
    .sys_reset(sys_reset_q),
    .load_value(wdog_load_q),
    .load_wr(wdog_load_wr_q),
    .int_en(wdog_ctrl_q[WDOG_INTEN_BIT]),
    .reset_en(wdog_ctrl_q[WDOG_RESEN_BIT]),
    .int_clear(wr_en && wr_addr_q == OFS_WDOG_INT_CLEAR),
    .count_q(wdog_count),
    .int_flag_q(wdog_irq_q),
    .reset_req_q(wdog_rst)
  );

  // reset sources
  logic bor_reset_src;
  logic rst_src;
  assign bor_reset_src = brownout_detect && pbor_q[PBOR_RST_EN_BIT]; // R3
  assign rst_src = !ext_reset_n || por_active || bor_reset_src || sw_req_q || wdog_rst; // R4

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_req_q <= 1'b0;
    end else begin
      sw_req_q <= wr_en && wr_addr_q == OFS_SYS_RESET_CTRL && wr_strb_q[0] && wr_data_q[SYS_REQ_BIT]; // R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_q <= 1'b1;
      rst_cnt_q <= RST_CNT_W'(RESET_MIN_CYC);
    end else if (rst_src) begin
      sys_reset_q <= 1'b1; // R4 R9
      rst_cnt_q <= RST_CNT_W'(RESET_MIN_CYC);
    end else begin
      sys_reset_q <= (rst_cnt_q != '0);
      if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - RST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bor_prev_q <= 1'b0;
    end else begin
      bor_prev_q <= brownout_detect;
    end
  end

  // brown-out interrupt path when reset is not enabled; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bor_irq_q <= 1'b0;
    end else if (brownout_detect && !bor_prev_q && !pbor_q[PBOR_RST_EN_BIT]) begin
      bor_irq_q <= 1'b1; // R2
    end else if (wr_en && wr_addr_q == OFS_BOR_STATUS && wr_strb_q[0] && wr_data_q[0]) begin
      bor_irq_q <= 1'b0;
    end
  end

  logic [CAUSE_W-1:0] cause_set;
  always_comb begin
    cause_set = '0;
    cause_set[CAUSE_EXT] = !ext_reset_n;
    cause_set[CAUSE_BOR] = bor_reset_src; // R5
    cause_set[CAUSE_WDOG] = wdog_rst;
    cause_set[CAUSE_SW] = sw_req_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || por_active) begin
      cause_q <= CAUSE_RESET; // R23
    end else if (wr_en && wr_addr_q == OFS_RESET_CAUSE) begin
      cause_q <= wr_merged[CAUSE_W-1:0] | cause_set;
    end else begin
      cause_q <= cause_q | cause_set; // R23
    end
  end

  // core start-up order after the internal reset releases
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset_q) begin
      boot_step_q <= BOOT_HOLD;
    end else begin
      case (boot_step_q)
        BOOT_HOLD: boot_step_q <= BOOT_FETCH_SP; // R10
        BOOT_FETCH_SP: boot_step_q <= BOOT_FETCH_PC;
        BOOT_FETCH_PC: boot_step_q <= BOOT_FETCH_INSN;
        BOOT_FETCH_INSN: boot_step_q <= BOOT_RUN;
        BOOT_RUN: boot_step_q <= BOOT_RUN;
        default: boot_step_q <= BOOT_HOLD;
      endcase
    end
  end

  // effective clock configuration
  logic use_ext;
  logic eff_bypass;
  logic eff_pwrdn;
  logic [2:0] eff_osc;
  logic [5:0] eff_sysdiv;
  assign use_ext = rcc_ext_q[EXT_USE_BIT]; // R19
  assign eff_bypass = use_ext ? rcc_ext_q[EXT_BYPASS_BIT] : rcc_q[RCC_BYPASS_BIT]; // R18
  assign eff_pwrdn = use_ext ? rcc_ext_q[EXT_PWRDN_BIT] : rcc_q[RCC_PWRDN_BIT];
  assign eff_osc = use_ext ? rcc_ext_q[EXT_OSCSRC_LSB +: 3] : {1'b0, rcc_q[RCC_OSCSRC_LSB +: 2]};
  assign eff_sysdiv = use_ext ? rcc_ext_q[EXT_SYSDIV_LSB +: 6] : {2'h0, rcc_q[RCC_SYSDIV_LSB +: 4]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_src_q <= SRC_IFAST;
      sysdiv_q <= 6'h0f;
      use_sysdiv_q <= 1'b0;
      pll_power_down_q <= 1'b1;
    end else begin
      if (por_active) begin
        clk_src_q <= SRC_IFAST; // R14
      end else if (!eff_bypass && !eff_pwrdn && pll_locked) begin
        clk_src_q <= SRC_PLL; // R16
      end else begin
        clk_src_q <= osc_decode(eff_osc); // R16
      end
      sysdiv_q <= eff_sysdiv;
      use_sysdiv_q <= rcc_q[RCC_USESYSDIV_BIT];
      pll_power_down_q <= eff_pwrdn;
    end
  end

  // converter clock enable, never faster than 16 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_cnt_q <= '0;
      conv_clk_tick_q <= 1'b0;
    end else if (conv_cnt_q == CONV_CNT_W'(CONV_DIV - 1)) begin
      conv_cnt_q <= '0;
      conv_clk_tick_q <= 1'b1; // R20
    end else begin
      conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
      conv_clk_tick_q <= 1'b0;
    end
  end

  // pwm clock enable divides by 2 to the power of field plus one
  logic [8:0] pwm_mask;
  assign pwm_mask = (9'h002 << rcc_q[RCC_PWMDIV_LSB +: 3]) - 9'h001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_q <= 8'h00;
      pwm_clk_tick_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_clk_tick_q <= !rcc_q[RCC_USEPWMDIV_BIT] || ((pwm_cnt_q & pwm_mask[7:0]) == pwm_mask[7:0]); // R21
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_boot_order;
    boot_step_q == BOOT_HOLD ##1 boot_step_q == BOOT_FETCH_SP ##1 boot_step_q == BOOT_FETCH_PC
      ##1 boot_step_q == BOOT_FETCH_INSN ##1 boot_step_q == BOOT_RUN;
  endsequence

  a_bor_reset_path: assert property ( // R3 R5
    (bor_reset_src && !por_active) |=> (sys_reset_q && cause_q[CAUSE_BOR]))
    else $error("enabled brown-out did not reset or record cause");
  a_bor_irq_path: assert property ( // R2
    (brownout_detect && !bor_prev_q && !pbor_q[PBOR_RST_EN_BIT]) |=> bor_irq_q)
    else $error("brown-out interrupt not raised");
  a_reset_gated_src: assert property ( // R1
    $rose(sys_reset_q) |-> $past(rst_src))
    else $error("system reset without an enabled source");
  a_sysreq_reset: assert property ( // R9
    sw_req_q |=> sys_reset_q [*8])
    else $error("software system reset too short");
  a_boot_sequence: assert property ( // R10
    ($fell(sys_reset_q) ##0 !rst_src) |-> s_boot_order)
    else $error("start-up fetch order broken");
  a_ext_override: assert property ( // R18
    (use_ext && rcc_ext_q[EXT_BYPASS_BIT] && rcc_ext_q[EXT_OSCSRC_LSB +: 3] == 3'h2 && !por_active)
      |=> clk_src_q == SRC_IFAST_DIV4)
    else $error("extended clock config not applied");
  a_base_select: assert property ( // R19
    (!use_ext && rcc_q[RCC_BYPASS_BIT] && rcc_q[RCC_OSCSRC_LSB +: 2] == 2'h3 && !por_active)
      |=> clk_src_q == SRC_LOW_30K)
    else $error("base clock config not applied");
  a_conv_tick_gap: assert property ( // R20
    conv_clk_tick_q |=> !conv_clk_tick_q [*8])
    else $error("converter clock faster than allowed");

endmodule : rcsc_top

`default_nettype wire

// ---- bench/reset_and_clock_source_control_test.sv ----
// Purpose: self-checking bench for rcsc_top
// Assumes: AXI4-Lite master tasks, seed 79
// Notes: outputs are sampled 1 ns after the edge
`default_nettype none
module reset_and_clock_source_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rcsc_pkg::*;
  logic aclk, aresetn, ext_reset_n, por_active, brownout_detect, pll_locked, lk;
  logic sys_reset_q, bor_irq_q, wdog_irq_q, use_sysdiv_q, pll_power_down_q, conv_clk_tick_q, pwm_clk_tick_q;
  rcsc_axi_req_t req;
  rcsc_axi_rsp_t rsp;
  rcsc_boot_t boot_step_q;
  rcsc_clk_src_t clk_src_q;
  logic [95:0] periph_reset_q, periph_clk_en_q;
  logic [5:0] sysdiv_q;
  logic [31:0] d, e;
  logic [1:0] r;
  int fail_count, checked, nc, np;
  logic [2:0] srcs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  rcsc_top #(.NUM_UNIT_REGS(3)) u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp_q(rsp),
    .ext_reset_n(ext_reset_n), .por_active(por_active), .brownout_detect(brownout_detect),
    .pll_locked(pll_locked), .sys_reset_q(sys_reset_q), .boot_step_q(boot_step_q), .bor_irq_q(bor_irq_q),
    .wdog_irq_q(wdog_irq_q), .periph_reset_q(periph_reset_q), .periph_clk_en_q(periph_clk_en_q),
    .clk_src_q(clk_src_q), .sysdiv_q(sysdiv_q), .use_sysdiv_q(use_sysdiv_q), .pll_power_down_q(pll_power_down_q),
    .conv_clk_tick_q(conv_clk_tick_q), .pwm_clk_tick_q(pwm_clk_tick_q));
  function automatic logic [2:0] exp_src(input logic [31:0] x, input logic l);
    if (!x[EXT_USE_BIT]) return SRC_IFAST;
    if (!x[EXT_BYPASS_BIT] && !x[EXT_PWRDN_BIT] && l) return SRC_PLL;
    return x[6:4];
  endfunction : exp_src
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      $display("unexpected %s expected %h seen %h", nm, ex, got);
      fail_count++;
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic wait_until(input int sel, input logic v);
    for (int n = 0; n < 2000; n++) begin
      @(posedge aclk);
      #1;
      if (((sel == 0) ? sys_reset_q : (sel == 1) ? wdog_irq_q : (boot_step_q == BOOT_RUN)) === v) return;
    end
    chk($sformatf("wait_%0d", sel), 0, 1);
    final_report();
  endtask : wait_until
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv);
    logic aw, w, b;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= dv;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      #1;
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b === 1'b1) begin
        req.bready <= 1'b0;
        return;
      end
    end
    chk("bvalid", 1, 0);
    final_report();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar, rv;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      #1;
      ar = req.arvalid & rsp.arready;
      rv = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
      if (rv === 1'b1) begin
        req.rready <= 1'b0;
        return;
      end
    end
    chk("rvalid", 1, 0);
    final_report();
  endtask : axi_rd
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {fail_count, checked, req, aresetn, por_active, brownout_detect, pll_locked} = '0;
    ext_reset_n = 1'b1;
    void'($urandom(79));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_until(2, 1);
    chk("clk_src", SRC_IFAST, clk_src_q);
    axi_rd(OFS_PBOR_CTRL);
    chk("bor_enable", 0, d);
    axi_rd(8'h80);
    chk("unmapped_resp", RESP_SLVERR, r);
    $display("test reset done");
    brownout_detect <= 1'b1;
    repeat (4) @(posedge aclk);
    #1;
    chk("bor_irq", 1, bor_irq_q);
    chk("sys_reset_off", 0, sys_reset_q);
    axi_wr(OFS_PBOR_CTRL, 32'h2);
    wait_until(0, 1);
    repeat (40) @(posedge aclk);
    #1;
    chk("bor_hold", 1, sys_reset_q);
    @(posedge aclk);
    brownout_detect <= 1'b0;
    wait_until(2, 1);
    axi_rd(OFS_RESET_CAUSE);
    chk("cause_bor", 1, d[CAUSE_BOR]);
    $display("test brownout done");
    for (int i = 0; i < 6; i++) begin
      e = $urandom;
      axi_wr(((i < 3) ? OFS_SOFT_RESET0 : OFS_CLK_GATE0) + 8'(4 * (i % 3)), e);
      @(posedge aclk);
      #1;
      chk("unit_vec", e, (i < 3) ? periph_reset_q[32 * i +: 32] : periph_clk_en_q[32 * (i - 3) +: 32]);
      if (i < 3) axi_wr(OFS_SOFT_RESET0 + 8'(4 * i), 32'h0);
    end
    chk("unit_rst_clear", 0, periph_reset_q[95:64]);
    $display("test units done");
    for (int i = 0; i < 8; i++) begin
      e = $urandom;
      e[6:4] = srcs[i % 5];
      e[EXT_USE_BIT] = (i != 7);
      lk = (i == 5) || ($urandom % 2 == 1);
      if (i == 5) {e[EXT_BYPASS_BIT], e[EXT_PWRDN_BIT]} = 2'b00;
      if (i == 2) e[EXT_BYPASS_BIT] = 1'b1;
      @(posedge aclk);
      pll_locked <= lk;
      axi_wr(OFS_RUN_CLK_CFG_EXT, e);
      repeat (2) @(posedge aclk);
      #1;
      chk("clk_src", exp_src(e, lk), clk_src_q);
      chk("sysdiv", e[31] ? e[28:23] : RCC_RESET[26:23], sysdiv_q);
      chk("pll_pwrdn", e[31] ? e[EXT_PWRDN_BIT] : RCC_RESET[RCC_PWRDN_BIT], pll_power_down_q);
    end
    axi_wr(OFS_RUN_CLK_CFG, RCC_RESET | 32'h0050_0030);
    repeat (2) @(posedge aclk);
    #1;
    chk("base_src", SRC_LOW_30K, clk_src_q);
    chk("use_sysdiv", 1, use_sysdiv_q);
    {nc, np} = '0;
    repeat (CONV_DIV * 256) begin
      @(posedge aclk);
      #1;
      nc += conv_clk_tick_q;
      np += pwm_clk_tick_q;
    end
    chk("conv_ticks", 256, nc);
    chk("pwm_ticks", CONV_DIV, np);
    $display("test clocks done");
    axi_wr(OFS_WDOG_LOAD, 32'd40);
    axi_wr(OFS_WDOG_CTRL, 32'h3);
    wait_until(1, 1);
    axi_rd(OFS_WDOG_VALUE);
    chk("wdog_reload", 1, d <= 40 && d > 30);
    wait_until(0, 1);
    wait_until(2, 1);
    axi_wr(OFS_SYS_RESET_CTRL, 32'h1);
    wait_until(0, 1);
    wait_until(2, 1);
    axi_rd(OFS_RESET_CAUSE);
    chk("cause_sticky", 3'h7, d[4:2]);
    @(posedge aclk);
    por_active <= 1'b1;
    @(posedge aclk);
    por_active <= 1'b0;
    wait_until(0, 1);
    wait_until(2, 1);
    axi_rd(OFS_RESET_CAUSE);
    chk("cause_por", 32'h2, d);
    $display("test resets done");
    final_report();
  end
endmodule : reset_and_clock_source_control_test
`default_nettype wire
